// *** verilog/tdmr_core.sv ***
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "tdmr_consts.svh"
// Notes on behaviour
// - local hi-rate bit high selects local 32 Mbps mode, low per-stream rates.
// - reset clears both hi-rate bits, ports start in selectable mode.
// - local stream rates come only from local mode and rate settings.
// - local input stream rate comes from its own two-bit field.
// - local output stream rate comes from its own two-bit field.
// - in 32 Mbps mode streams 0-7 run fixed, 8-15 unused.
// - backplane hi-rate bit high selects backplane 32 Mbps mode.
// - backplane rates come only from backplane mode and rate settings.
// - backplane input stream rate comes from its own two-bit field.
// - backplane output stream rate comes from its own two-bit field.
// - input streams align to master frame pulse and master clock.
// - local connection word selects message mode, enable and source memory.
// - backplane connection word selects message mode, enable and source memory.
// - frame pulse style, falling-edge or GCI, is detected automatically.
// - generated frame pulses follow the detected style and width.
// - edge select bit picks master clock edge, falling by default.
// - output clock polarity bit sets output clock levels at frame boundary.
// - an internal fast timebase is derived from the master clock.
// - byte received in frame N is sent in frame N+2.
// - width bit accepts and generates double-width frame pulses.
// - rate fields of a port are ignored while it is in 32 Mbps mode.
module tdmr_core (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic master_clock_in,
	input wire logic master_frame_pulse_in,
	input wire logic [15:0] local_in_streams,
	input wire logic [15:0] bkpl_in_streams,
	output logic [15:0] local_out_streams,
	output logic [15:0] local_out_streams_oe,
	output logic [15:0] bkpl_out_streams,
	output logic [15:0] bkpl_out_streams_oe,
	output logic frame_pulse_out_8m,
	output logic frame_pulse_out_16m,
	output logic clock_out_8m,
	output logic clock_out_16m
);
	import tdmr_pkg::*;

	tdmr_st_t st;
	tdmr_st_t n;
	logic [1:0] rq;
	logic rst_ni;
	tdmr_rate_t rt [2];
	// three frame banks per port: write one, read the one written two frames ago
	logic [7:0] dmem [2][3][16][512];
	tdmr_cm_t cm [2][16][512];
	logic edge_evt;
	logic qtick;
	logic fbound;
	logic fp_act;
	logic wr_go;
	logic [31:0] wm;
	logic [1:0] rb;
	logic [1:0][15:0] wen;
	logic [1:0][15:0][8:0] wch;

	// ====================================================
	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rq <= 2'b00;
		end else begin
			rq <= {rq[0], 1'b1};
		end
	end
	assign rst_ni = rq[1];

	// ====================================================
	// helpers
	function automatic logic [1:0] mod3_inc(input logic [1:0] v);
		return (v == 2'd2) ? 2'd0 : 2'(v + 2'd1);
	endfunction: mod3_inc
	function automatic logic addr_ok(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= `TDMR_A_CMD;
	endfunction: addr_ok
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int k = 0; k < 4; k++) begin
			if (s[k]) begin
				r[8*k +: 8] = d[8*k +: 8];
			end
		end
		return r;
	endfunction: merge

	// register view shared by the read path and the byte-lane merge
	function automatic logic [31:0] reg_val(input logic [7:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			`TDMR_A_CTRL: begin
				v[4:0] = st.ctrl;
				v[`TDMR_ST_GCI] = st.gci;
				v[`TDMR_ST_LOCK] = st.lock;
			end
			`TDMR_A_LIR: v = st.lir;
			`TDMR_A_LOR: v = st.lor;
			`TDMR_A_BIR: v = st.bir;
			`TDMR_A_BOR: v = st.bor;
			`TDMR_A_CMA: v[13:0] = st.cma;
			`TDMR_A_CMD: v[15:0] = cm[st.cma[`TDMR_CMA_PORT]][st.cma[`TDMR_CMA_STRM]]
				[st.cma[`TDMR_CMA_CH]];
			default: v = '0;
		endcase
		return v;
	endfunction: reg_val

	// ====================================================
	// each port decodes only its own mode bit and rate fields
	tdmr_port_rates u_local_rates (
		.clk(clk),
		.rst_n(rst_ni),
		.hi_rate_mode(st.ctrl.lhi),
		.in_rate_field(st.lir),
		.out_rate_field(st.lor),
		.rt(rt[0])
	);
	tdmr_port_rates u_bkpl_rates (
		.clk(clk),
		.rst_n(rst_ni),
		.hi_rate_mode(st.ctrl.bhi),
		.in_rate_field(st.bir),
		.out_rate_field(st.bor),
		.rt(rt[1])
	);

	// ====================================================
	// timebase: master clock edges, quarter-period ticks and frame boundary
	assign edge_evt = (st.ms[2] != st.ms[1]) && (st.ms[1] == st.ctrl.iedge);
	// quarter ticks spread evenly over the measured master period
	assign qtick = edge_evt || (st.qn != 2'd3 && st.plen[7:2] != 6'd0 &&
		9'(st.sc) + 9'd1 >= {3'd0, st.plen[7:2]});
	assign fp_act = st.lock && (st.fs[1] == st.gci);
	// double-width pulse marks the boundary on its second sample
	assign fbound = edge_evt && fp_act && st.pcnt == {1'b0, st.ctrl.pw};
	assign wr_go = st.awv && st.wv;
	assign wm = merge(reg_val(st.aa), st.wd, st.ws);
	assign rb = mod3_inc(st.fb);

	// ====================================================
	// next state
	always_comb begin
		logic [2:0] s;
		logic [11:0] m;
		logic [11:0] bi;
		tdmr_cm_t w;
		logic [7:0] byt;
		n = st;
		wen = '0;
		wch = '0;
		s = '0;
		m = '0;
		bi = '0;
		w = '0;
		byt = '0;
		// bus slave: address and data are taken independently
		if (s_axi_awvalid && s_axi_awready) begin
			n.awv = 1'b1;
			n.aa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.wv = 1'b1;
			n.wd = s_axi_wdata;
			n.ws = s_axi_wstrb;
		end
		if (wr_go) begin
			n.awv = 1'b0;
			n.wv = 1'b0;
			n.bv = 1'b1;
			n.br = addr_ok(st.aa) ? `TDMR_RESP_OK : `TDMR_RESP_ERR;
			case (st.aa)
				`TDMR_A_CTRL: n.ctrl = wm[4:0];
				`TDMR_A_LIR: n.lir = wm;
				`TDMR_A_LOR: n.lor = wm;
				`TDMR_A_BIR: n.bir = wm;
				`TDMR_A_BOR: n.bor = wm;
				`TDMR_A_CMA: n.cma = wm[13:0];
				default: n.ctrl = st.ctrl;
			endcase
		end
		if (st.bv && s_axi_bready) begin
			n.bv = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			n.rv = 1'b1;
			n.rd = reg_val(s_axi_araddr);
			n.rr = addr_ok(s_axi_araddr) ? `TDMR_RESP_OK : `TDMR_RESP_ERR;
		end else if (st.rv && s_axi_rready) begin
			n.rv = 1'b0;
		end
		// synchronisers for every pin from the link side
		n.ms = {st.ms[1:0], master_clock_in};
		n.fs = {st.fs[0], master_frame_pulse_in};
		n.d1 = {bkpl_in_streams, local_in_streams};
		n.d2 = st.d1;
		// period measure, saturating so a stopped clock cannot wrap
		n.pc = edge_evt ? 8'd0 : ((st.pc == 8'hff) ? st.pc : 8'(st.pc + 8'd1));
		if (edge_evt) begin
			n.plen = 8'(st.pc + 8'd1);
		end
		n.sc = qtick ? 8'd0 : 8'(st.sc + 8'd1);
		n.qn = edge_evt ? 2'd0 : (qtick ? 2'(st.qn + 2'd1) : st.qn);
		n.qs = qtick;
		if (fbound) begin
			n.q = '0;
			n.fb = mod3_inc(st.fb);
		end else if (qtick) begin
			n.q = 12'(st.q + 12'd1);
		end
		// style detection: a long steady run is the idle level
		if (edge_evt) begin
			n.lastfp = st.fs[1];
			n.run = (st.fs[1] != st.lastfp) ? 3'd0 :
				((st.run == 3'd7) ? st.run : 3'(st.run + 3'd1));
			if (st.run >= `TDMR_FP_IDLE_RUN && st.fs[1] == st.lastfp) begin
				n.gci = !st.fs[1];
				n.lock = 1'b1;
			end
			n.pcnt = fp_act ? ((st.pcnt == 2'd3) ? st.pcnt : 2'(st.pcnt + 2'd1)) : 2'd0;
		end
		// generated pulses and clocks, aligned to the quarter count
		if (st.qs) begin
			n.fp8 = (st.q < (st.ctrl.pw ? 12'd8 : 12'd4)) ~^ st.gci;
			n.fp16 = (st.q < (st.ctrl.pw ? 12'd4 : 12'd2)) ~^ st.gci;
			n.c8 = st.ctrl.ohpol ^ st.q[1];
			n.c16 = st.ctrl.ohpol ^ st.q[0];
		end
		// per stream sampling and output shifting
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 16; i++) begin
				s = rt[p].ish[i];
				m = 12'((12'h1 << s) - 12'h1);
				bi = st.q >> s;
				// sample mid-bit; at the top rate the one tick is the sample
				if (st.qs && rt[p].iuse[i] && (st.q & m) == 12'((12'h1 << s) >> 1)) begin
					n.sh[p][i] = {st.sh[p][i][6:0], st.d2[p][i]};
					wen[p][i] = (bi[2:0] == 3'd7);
					wch[p][i] = bi[11:3];
				end
				s = rt[p].osh[i];
				m = 12'((12'h1 << s) - 12'h1);
				bi = st.q >> s;
				if (st.qs && (st.q & m) == 12'h000) begin
					w = cm[p][i][bi[11:3]];
					byt = w.src ? dmem[1][rb][w.strm][w.ch] : dmem[0][rb][w.strm][w.ch];
					if (w.msg) begin
						byt = w[7:0];
					end
					n.dout[p][i] = byt[3'd7 - bi[2:0]];
					n.oe[p][i] = st.lock && rt[p].ouse[i] && w.ena;
				end
			end
		end
	end

	// ====================================================
	// state register
	always_ff @(posedge clk or negedge rst_ni) begin
		if (!rst_ni) begin
			st <= '0;
		end else begin
			st <= n;
		end
	end

	// ====================================================
	// data memory writes land in the current bank, connection words by software
	always_ff @(posedge clk) begin
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 16; i++) begin
				if (wen[p][i]) begin
					dmem[p][st.fb][i][wch[p][i]] <= n.sh[p][i];
				end
			end
		end
		if (rst_ni && wr_go && st.aa == `TDMR_A_CMD) begin
			cm[st.cma[`TDMR_CMA_PORT]][st.cma[`TDMR_CMA_STRM]][st.cma[`TDMR_CMA_CH]] <= wm[15:0];
		end
	end

	// ====================================================
	// outputs
	assign s_axi_awready = !st.awv && !st.bv;
	assign s_axi_wready = !st.wv && !st.bv;
	assign s_axi_bvalid = st.bv;
	assign s_axi_bresp = st.br;
	assign s_axi_arready = !st.rv;
	assign s_axi_rvalid = st.rv;
	assign s_axi_rdata = st.rd;
	assign s_axi_rresp = st.rr;
	assign local_out_streams = st.dout[0];
	assign local_out_streams_oe = st.oe[0];
	assign bkpl_out_streams = st.dout[1];
	assign bkpl_out_streams_oe = st.oe[1];
	assign frame_pulse_out_8m = st.fp8;
	assign frame_pulse_out_16m = st.fp16;
	assign clock_out_8m = st.c8;
	assign clock_out_16m = st.c16;

	// ====================================================
	// checks
	property p_rst_modes;
		@(posedge clk) disable iff (!rst_ni)
		$rose(rst_ni) |-> !st.ctrl.lhi && !st.ctrl.bhi ##1 !st.ctrl.lhi;
	endproperty
	a_rst_modes: assert property (p_rst_modes) else $error("modes not clear after reset");
	property p_edge;
		@(posedge clk) disable iff (!rst_ni)
		edge_evt |-> st.ms[1] == st.ctrl.iedge && st.ms[2] != st.ctrl.iedge;
	endproperty
	a_edge: assert property (p_edge) else $error("wrong master clock edge");
	property p_clk_pol;
		@(posedge clk) disable iff (!rst_ni)
		st.qs && st.q == 12'd0 |=> clock_out_8m == st.ctrl.ohpol && clock_out_16m == st.ctrl.ohpol;
	endproperty
	a_clk_pol: assert property (p_clk_pol) else $error("output clock level at boundary");
	property p_fp_idle;
		@(posedge clk) disable iff (!rst_ni)
		st.qs && st.q == 12'd100 |=> frame_pulse_out_8m == !st.gci && frame_pulse_out_16m == !st.gci;
	endproperty
	a_fp_idle: assert property (p_fp_idle) else $error("frame pulse idle level");
	property p_fp_width;
		@(posedge clk) disable iff (!rst_ni)
		st.qs && st.q == 12'd5 |=> frame_pulse_out_8m == (st.ctrl.pw ~^ st.gci);
	endproperty
	a_fp_width: assert property (p_fp_width) else $error("frame pulse width");
	property p_delay;
		@(posedge clk) disable iff (!rst_ni)
		fbound |=> st.fb == mod3_inc($past(st.fb)) && st.q == 12'd0;
	endproperty
	a_delay: assert property (p_delay) else $error("bank rotation broken");
	property p_unused;
		@(posedge clk) disable iff (!rst_ni)
		st.ctrl.lhi && st.qs |=> st.oe[0][15:8] == 8'h00;
	endproperty
	a_unused: assert property (p_unused) else $error("unused stream driven");
	property p_bhold;
		@(posedge clk) disable iff (!rst_ni)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule: tdmr_core

// *** verilog/tdmr_consts.svh ***
`ifndef TDMR_CONSTS_SVH
`define TDMR_CONSTS_SVH
// ====================================================
// register byte offsets
`define TDMR_A_CTRL 8'h00
`define TDMR_A_LIR 8'h04
`define TDMR_A_LOR 8'h08
`define TDMR_A_BIR 8'h0c
`define TDMR_A_BOR 8'h10
`define TDMR_A_CMA 8'h14
`define TDMR_A_CMD 8'h18
// ====================================================
// status bit positions in the control word read-back
`define TDMR_ST_GCI 9
`define TDMR_ST_LOCK 10
// connection address fields
`define TDMR_CMA_PORT 13
`define TDMR_CMA_STRM 12:9
`define TDMR_CMA_CH 8:0
// ====================================================
// reset values and timing counts
`define TDMR_CTRL_RST 5'h00
`define TDMR_FP_IDLE_RUN 3'd3
`define TDMR_NO_SHIFT 3'd4
`define TDMR_RESP_OK 2'b00
`define TDMR_RESP_ERR 2'b10
`endif

// *** verilog/tdmr_pkg.sv ***
package tdmr_pkg;
	// ====================================================
	// control bits that software writes
	typedef struct packed {
		logic ohpol;
		logic iedge;
		logic pw;
		logic bhi;
		logic lhi;
	} tdmr_ctrl_t;
	// one connection word per output channel
	typedef struct packed {
		logic msg;
		logic ena;
		logic src;
		logic [3:0] strm;
		logic [8:0] ch;
	} tdmr_cm_t;
	// per-stream bit-rate shifts of one port (shift 0 is the 32 Mbps rate)
	typedef struct packed {
		logic [15:0][2:0] ish;
		logic [15:0][2:0] osh;
		logic [15:0] iuse;
		logic [15:0] ouse;
	} tdmr_rate_t;
	// register state of the core, apart from the reset flops and the data and connection memories
	typedef struct packed {
		logic awv;
		logic wv;
		logic bv;
		logic rv;
		logic [7:0] aa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic [1:0] br;
		logic [1:0] rr;
		logic [31:0] rd;
		tdmr_ctrl_t ctrl;
		logic [31:0] lir;
		logic [31:0] lor;
		logic [31:0] bir;
		logic [31:0] bor;
		logic [13:0] cma;
		logic [2:0] ms;
		logic [1:0] fs;
		logic [7:0] pc;
		logic [7:0] plen;
		logic [7:0] sc;
		logic [1:0] qn;
		logic qs;
		logic [11:0] q;
		logic [2:0] run;
		logic lastfp;
		logic gci;
		logic lock;
		logic [1:0] pcnt;
		logic [1:0] fb;
		logic [1:0][15:0][7:0] sh;
		logic [1:0][15:0] d1;
		logic [1:0][15:0] d2;
		logic [1:0][15:0] dout;
		logic [1:0][15:0] oe;
		logic fp8;
		logic fp16;
		logic c8;
		logic c16;
	} tdmr_st_t;
endpackage: tdmr_pkg

// *** verilog/tdmr_port_rates.sv ***
`timescale 1ns/10ps
`include "tdmr_consts.svh"
// ====================================================
// rate decode of one port, fed only by that port's own bits
module tdmr_port_rates (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hi_rate_mode,
	input wire logic [31:0] in_rate_field,
	input wire logic [31:0] out_rate_field,
	output tdmr_pkg::tdmr_rate_t rt
);
	import tdmr_pkg::*;

	// ====================================================
	// per stream: fixed top rate on 0-7 in hi mode, else own 2-bit field
	always_comb begin
		rt = '0;
		for (int i = 0; i < 16; i++) begin
			if (hi_rate_mode) begin
				rt.iuse[i] = (i < 8);
				rt.ouse[i] = (i < 8);
			end else begin
				rt.ish[i] = 3'(`TDMR_NO_SHIFT - {1'b0, in_rate_field[2*i +: 2]});
				rt.osh[i] = 3'(`TDMR_NO_SHIFT - {1'b0, out_rate_field[2*i +: 2]});
				rt.iuse[i] = 1'b1;
				rt.ouse[i] = 1'b1;
			end
		end
	end

	property p_hi_fixed;
		@(posedge clk) disable iff (!rst_n)
		hi_rate_mode |-> rt.ish[7:0] == '0 && rt.osh[7:0] == '0 && rt.ouse == 16'h00ff;
	endproperty
	a_hi_fixed: assert property (p_hi_fixed) else $error("hi mode rates not fixed");
	property p_in_sel;
		@(posedge clk) disable iff (!rst_n)
		!hi_rate_mode |-> rt.ish[3] == 3'(3'd4 - {1'b0, in_rate_field[7:6]}) && rt.iuse[12];
	endproperty
	a_in_sel: assert property (p_in_sel) else $error("input rate field ignored");
	property p_out_sel;
		@(posedge clk) disable iff (!rst_n)
		!hi_rate_mode |-> rt.osh[8] == 3'(3'd4 - {1'b0, out_rate_field[17:16]});
	endproperty
	a_out_sel: assert property (p_out_sel) else $error("output rate field ignored");
endmodule: tdmr_port_rates

// *** tb/tdmr_far_end.sv ***
`timescale 1ns/10ps
// ====================================================
// far-end timing source and framers
module tdmr_far_end (
	input wire logic gci_style,
	output logic master_clock_in,
	output logic master_frame_pulse_in,
	output logic [15:0] local_in_streams,
	output logic [15:0] bkpl_in_streams
);
	int k;
	// 1024 periods of 160 ns make one 163.84 us frame; the pulse spans one period
	// and straddles the active edge of its style, so it is sampled once
	initial begin
		k = 0;
		master_clock_in = 1'b1;
		master_frame_pulse_in = !gci_style;
		local_in_streams = 16'hff00;
		bkpl_in_streams = 16'hff00;
		#7;
		forever begin
			master_clock_in = 1'b1;
			if (!gci_style) master_frame_pulse_in = (k != 0);
			// streams 8-15 held high, never left floating
			local_in_streams = {8'hff, local_in_streams[7:0] ^ 8'h5a};
			bkpl_in_streams = {8'hff, 8'(k)};
			#80;
			master_clock_in = 1'b0;
			if (gci_style) master_frame_pulse_in = (k == 1023);
			k = (k + 1) % 1024;
			#80;
		end
	end
endmodule: tdmr_far_end

// *** tb/tdm_port_rate_frame_timing_tb.sv ***
`timescale 1ns/10ps
`include "tdmr_consts.svh"
module tdm_port_rate_frame_timing_tb;
	localparam int W = 2048;
	logic clk, rst_n, gci;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic mclk, mfp, fp8, fp16, c8, c16;
	logic [15:0] lin, bin, lout, loe, bout, boe;
	logic [4:0] ph [3] = '{5'h00, 5'h11, 5'h02};
	int err_total, n_tests;
	int cnt [11];

	tdmr_core u_tdmr_core (.clk(clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .master_clock_in(mclk),
		.master_frame_pulse_in(mfp), .local_in_streams(lin), .bkpl_in_streams(bin),
		.local_out_streams(lout), .local_out_streams_oe(loe),
		.bkpl_out_streams(bout), .bkpl_out_streams_oe(boe),
		.frame_pulse_out_8m(fp8), .frame_pulse_out_16m(fp16),
		.clock_out_8m(c8), .clock_out_16m(c16));

	tdmr_far_end u_tdmr_far_end (.gci_style(gci), .master_clock_in(mclk),
		.master_frame_pulse_in(mfp), .local_in_streams(lin), .bkpl_in_streams(bin));

	// ====================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("BAD %s exp %h got %h", nm, exp, got);
			err_total++;
		end
	endtask: chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask: summarize

	// ready is sampled mid-cycle: it only moves on rising edges
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic sa, sw, sb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		sb = 1'b0;
		while (!sb) begin
			@(negedge clk);
			sa = awvalid && awready;
			sw = wvalid && wready;
			sb = bvalid;
			rsp = bresp;
			@(posedge clk);
			if (sa) awvalid <= 1'b0;
			if (sw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask: axw

	task automatic axr(input logic [7:0] a);
		logic sa, sr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		sr = 1'b0;
		while (!sr) begin
			@(negedge clk);
			sa = arvalid && arready;
			sr = rvalid;
			rd = rdata;
			rsp = rresp;
			@(posedge clk);
			if (sa) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask: axr

	task automatic wait_lock();
		rd = '0;
		while (rd[`TDMR_ST_LOCK] !== 1'b1) axr(`TDMR_A_CTRL);
	endtask: wait_lock

	// counts over one window that opens at a generated frame boundary
	task automatic meas(input logic act, input logic pol);
		logic p8, p16, pl, pb;
		cnt = '{default: 0};
		@(negedge clk);
		while (fp8 === act) @(negedge clk);
		while (fp8 !== act) @(negedge clk);
		chk("c8 at boundary", c8, pol);
		chk("c16 at boundary", c16, pol);
		p8 = c8;
		p16 = c16;
		pl = lout[8];
		pb = bout[8];
		repeat (W) begin
			cnt[0] += (fp8 === act);
			cnt[1] += (fp16 === act);
			cnt[2] += (loe[8] === 1'b1);
			cnt[3] += (boe[8] === 1'b1);
			cnt[4] += (lout[8] === 1'b1);
			cnt[5] += (bout[8] === 1'b1);
			cnt[10] += (lout[9] === 1'b1);
			@(negedge clk);
			cnt[6] += (c8 !== p8);
			cnt[7] += (c16 !== p16);
			cnt[8] += (lout[8] !== pl);
			cnt[9] += (bout[8] !== pb);
			p8 = c8;
			p16 = c16;
			pl = lout[8];
			pb = bout[8];
		end
		chk("fp8 width", cnt[0], 8);
		chk("fp16 width", cnt[1], 4);
		chk("c8 edges", cnt[6], W / 4);
		chk("c16 edges", cnt[7], W / 2);
	endtask: meas

	// ====================================================
	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// a hang beyond 2 ms, nearly three times the planned run, is a failure
	initial begin
		#2_000_000;
		err_total++;
		summarize();
	end

	// ====================================================
	// main sequence
	initial begin
		{rst_n, gci, awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		err_total = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		axr(`TDMR_A_CTRL);
		chk("ctrl reset", rd & 32'h1f, 32'h0);
		axw(8'h1c, 32'h1);
		chk("bresp unmapped", rsp, `TDMR_RESP_ERR);
		axw(8'h02, 32'h1);
		chk("bresp unaligned", rsp, `TDMR_RESP_ERR);
		axr(8'h1c);
		chk("rresp unmapped", rsp, `TDMR_RESP_ERR);
		chk("rdata unmapped", rd, 32'h0);
		// local stream 8 at 4.096 Mbps (64 channels), backplane stream 8 at 2.048
		axw(`TDMR_A_LIR, 32'h0);
		axw(`TDMR_A_LOR, 32'h0001_0000);
		axw(`TDMR_A_BIR, 32'h0);
		axw(`TDMR_A_BOR, 32'h0);
		for (int i = 0; i < 64; i++) begin
			axw(`TDMR_A_CMA, {18'h0, 1'b0, 4'd8, 9'(i)});
			axw(`TDMR_A_CMD, 32'h0000_c0a5);
			if (i < 32) begin
				axw(`TDMR_A_CMA, {18'h0, 1'b1, 4'd8, 9'(i)});
				axw(`TDMR_A_CMD, 32'h0000_c081);
				// local stream 9 switched from backplane input stream 8, same channel
				axw(`TDMR_A_CMA, {18'h0, 1'b0, 4'd9, 9'(i)});
				axw(`TDMR_A_CMD, {16'h0, 3'b011, 4'd8, 9'(i)});
			end
		end
		chk("bresp cm", rsp, `TDMR_RESP_OK);
		wait_lock();
		chk("style falling", rd[`TDMR_ST_GCI], 1'b0);
		// each mode pattern: expected edges and ones follow from the rate code
		foreach (ph[i]) begin
			axw(`TDMR_A_CTRL, {27'h0, ph[i]});
			axr(`TDMR_A_CTRL);
			chk("ctrl readback", rd & 32'h1f, {27'h0, ph[i]});
			meas(1'b0, ph[i][4]);
			chk("local oe", cnt[2], ph[i][0] ? 0 : W);
			chk("bkpl oe", cnt[3], ph[i][1] ? 0 : W);
			if (!ph[i][0]) begin
				chk("local ones", cnt[4], W / 2);
				chk("local edges", cnt[8], W * 6 / 128);
			end
			if (!ph[i][1]) begin
				chk("bkpl ones", cnt[5], W / 4);
				chk("bkpl edges", cnt[9], W * 2 / 256);
			end
			// third window reads the bank filled two frames back from the all-ones input
			if (i == 2) chk("local switched ones", cnt[10], W);
		end
		// second style after a fresh reset, rising edge chosen to match
		@(posedge clk);
		rst_n <= 1'b0;
		gci <= 1'b1;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		axw(`TDMR_A_CTRL, 32'h8);
		wait_lock();
		chk("style gci", rd[`TDMR_ST_GCI], 1'b1);
		meas(1'b1, 1'b0);
		summarize();
	end
endmodule: tdm_port_rate_frame_timing_tb
